// ==== common/ddc_pkg.sv ====
// shared constants, types and arithmetic helpers for the down-converter datapath
package ddc_pkg;

	// datapath widths and counts
	localparam int SAMP_W = 12;              // converter sample width
	localparam int OUT_W  = 15;              // filter output width
	localparam int WORD_W = 16;              // output word width
	localparam int NCO_N  = 4;               // ncos per channel
	localparam int CH_N   = 2;               // channels
	localparam int ST_N   = 4;               // half-band stages
	localparam int TAP_N  = 11;              // taps per stage delay line
	localparam int MEM_N  = 16;              // word memory depth
	localparam int ACC_W  = 32;              // phase accumulator width
	localparam int PH_W   = 16;              // phase offset width

	// register index map (byte address is index times four)
	localparam logic [4:0] A_FREQ_A = 5'h00;  // freq_word_chan_a 0..3
	localparam logic [4:0] A_FREQ_B = 5'h04;  // freq_word_chan_b 0..3
	localparam logic [4:0] A_PHAS_A = 5'h08;  // phase_offset_chan_a 0..3
	localparam logic [4:0] A_PHAS_B = 5'h0C;  // phase_offset_chan_b 0..3
	localparam logic [4:0] A_CTRL   = 5'h10;  // control bits
	localparam logic [4:0] A_RDIV   = 5'h11;  // rational_divider
	localparam logic [4:0] A_STAT   = 5'h12;  // sync event counter

	// control register fields
	localparam int B_ILA   = 0;              // sync_on_lane_alignment
	localparam int B_NEXT  = 1;              // sync_on_next_reference
	localparam int B_LINK  = 2;              // link_enable
	localparam int B_D4W   = 3;              // dec4_wide_passband
	localparam int F_DEC   = 4;              // link_mode_select, 3 bits
	localparam int F_SELA  = 8;              // selected nco, channel a
	localparam int F_SELB  = 10;             // selected nco, channel b

	// misc constants
	localparam logic [31:0] PH_MASK  = 32'h0000_FFFF; // phase slot data mask
	localparam logic [5:0]  RDIV_PAD = 6'h00;         // times 64
	localparam logic [21:0] RCNT_ONE = 22'h00_0001;
	localparam logic [15:0] PH_ZERO  = 16'h0000;      // low half of offset
	localparam logic [2:0]  FILL_Z   = 3'h0;          // 12 to 15 bit scale
	localparam logic [3:0]  BYP_Z    = 4'h0;          // bypass low bits

	// decimation setting
	typedef enum logic [2:0] {
		DDC_BYPASS = 3'b000,
		DDC_DEC2   = 3'b001,
		DDC_DEC4   = 3'b010,
		DDC_DEC8   = 3'b011,
		DDC_DEC16  = 3'b100
	} ddc_dec_t;

	// half-band coefficients, normal set and wide-passband set
	localparam logic signed [15:0] HB_N5 = 16'sh006D;
	localparam logic signed [15:0] HB_N3 = -16'sh0345;
	localparam logic signed [15:0] HB_N1 = 16'sh12D8;
	localparam logic signed [15:0] HB_NC = 16'sh2000;
	localparam int                 HB_NS = 14;
	localparam logic signed [15:0] HB_W3 = -16'sh0041;
	localparam logic signed [15:0] HB_W1 = 16'sh0241;
	localparam logic signed [15:0] HB_WC = 16'sh0400;
	localparam int                 HB_WS = 11;

	// word memory state
	typedef struct packed {
		logic [MEM_N-1:0][31:0] w;   // stored words
		logic [31:0]            rd;  // registered read data
	} ddc_mem_state_t;

	// quarter-wave sine, k in 0..16, amplitude 2047
	function automatic logic [11:0] ddc_qsin(input logic [4:0] k);
		case (k)
			5'h00: ddc_qsin = 12'h000;
			5'h01: ddc_qsin = 12'h0C9;
			5'h02: ddc_qsin = 12'h190;
			5'h03: ddc_qsin = 12'h252;
			5'h04: ddc_qsin = 12'h30F;
			5'h05: ddc_qsin = 12'h3C5;
			5'h06: ddc_qsin = 12'h471;
			5'h07: ddc_qsin = 12'h513;
			5'h08: ddc_qsin = 12'h5A7;
			5'h09: ddc_qsin = 12'h62E;
			5'h0A: ddc_qsin = 12'h6A6;
			5'h0B: ddc_qsin = 12'h70D;
			5'h0C: ddc_qsin = 12'h763;
			5'h0D: ddc_qsin = 12'h7A7;
			5'h0E: ddc_qsin = 12'h7D8;
			5'h0F: ddc_qsin = 12'h7F5;
			default: ddc_qsin = 12'h7FF;
		endcase
	endfunction : ddc_qsin

	// full-circle sine from the top six phase bits
	function automatic logic signed [11:0] ddc_sin(input logic [5:0] p);
		logic [4:0]  k;
		logic [11:0] m;
		k = p[4] ? (5'h10 - {1'b0, p[3:0]}) : {1'b0, p[3:0]};
		m = ddc_qsin(k);
		ddc_sin = p[5] ? -$signed(m) : $signed(m);
	endfunction : ddc_sin

	// one half-band output from an 11-tap line, symmetric about tap 5
	function automatic logic [14:0] ddc_hb(input logic [10:0][14:0] t, input logic wide);
		logic signed [31:0] a5;
		logic signed [31:0] a3;
		logic signed [31:0] a1;
		logic signed [31:0] ac;
		logic signed [31:0] s;
		a5 = 32'(signed'(t[0])) + 32'(signed'(t[10]));
		a3 = 32'(signed'(t[2])) + 32'(signed'(t[8]));
		a1 = 32'(signed'(t[4])) + 32'(signed'(t[6]));
		ac = 32'(signed'(t[5]));
		if (wide) begin
			s = (HB_W3 * a3 + HB_W1 * a1 + HB_WC * ac) >>> HB_WS;
		end else begin
			s = (HB_N5 * a5 + HB_N3 * a3 + HB_N1 * a1 + HB_NC * ac) >>> HB_NS;
		end
		ddc_hb = s[14:0];
	endfunction : ddc_hb

endpackage : ddc_pkg

// ==== tb/ddc_link_rx.sv ====
// link receiver model driving the sync request line
`timescale 1ns/100ps
module ddc_link_rx (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst,
	// link control
	input  wire logic i_link_enable,
	input  wire logic i_slow,
	output logic      o_sync_n
);
	logic [5:0] cnt_q; // cycles left in code group sync
	logic       en_q;  // link enable last cycle
	// hold high, drop on link start, release once
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_q    <= 6'h00;
			en_q     <= 1'b0;
			o_sync_n <= 1'b1; // idle released
		end else begin
			en_q <= i_link_enable;
			if (i_link_enable && !en_q) begin
				cnt_q    <= i_slow ? 6'h28 : 6'h04; // prompt or slow lock
				o_sync_n <= 1'b0; // request code group sync
			end else if (cnt_q != 6'h00) begin
				cnt_q    <= cnt_q - 6'h01;
				o_sync_n <= (cnt_q == 6'h01); // single common release
			end else if (!i_link_enable) begin
				o_sync_n <= 1'b1; // high before link start
			end
		end
	end
endmodule : ddc_link_rx

// ==== tb/ddc_nco_decim_chk.sv ====
// port assertions for the down-converter datapath
`timescale 1ns/100ps
module ddc_nco_decim_chk (
	// clock and reset
	input wire logic                       i_clk,
	input wire logic                       i_rst,
	// watched inputs
	input wire logic [ddc_pkg::SAMP_W-1:0] i_sample_a,
	input wire logic [ddc_pkg::SAMP_W-1:0] i_sample_b,
	input wire logic                       i_sync_n,
	input wire logic                       i_sysref,
	input wire logic                       i_reg_wr,
	input wire logic                       i_reg_rd,
	input wire logic [4:0]                 i_reg_addr,
	input wire logic [31:0]                i_reg_wdata,
	// watched outputs
	input wire logic                       o_reg_rvalid,
	input wire logic                       o_dout_valid,
	input wire logic [ddc_pkg::WORD_W-1:0] o_dout_i_a,
	input wire logic [ddc_pkg::WORD_W-1:0] o_dout_q_a,
	input wire logic [ddc_pkg::WORD_W-1:0] o_dout_i_b,
	input wire logic [ddc_pkg::WORD_W-1:0] o_dout_q_b,
	input wire logic                       o_link_enable
);
	import ddc_pkg::*;
	logic [11:0] ctrl_q; // shadow of control bits
	logic [5:0]  stab_q; // cycles since last disturbance
	logic [4:0]  gap_q;  // cycles since last strobe
	logic        sn_q;   // sync line last cycle
	logic        sr_q;   // reference last cycle
	logic [2:0]  mode;   // effective decimation code
	logic [4:0]  fact;   // expected strobe period
	logic        calm;   // pipeline settled
	// unknown codes fall back to bypass
	always_comb begin
		mode = (ctrl_q[6:4] > 3'h4) ? 3'h0 : ctrl_q[6:4];
		fact = (mode == 3'h0) ? 5'h01 : (5'h01 << mode);
		calm = (stab_q == 6'h3F);
	end
	// shadow control, settle and gap counters
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ctrl_q <= 12'h000;
			stab_q <= 6'h00;
			gap_q  <= 5'h00;
			sn_q   <= 1'b1;
			sr_q   <= 1'b0;
		end else begin
			sn_q  <= i_sync_n;
			sr_q  <= i_sysref;
			gap_q <= o_dout_valid ? 5'h01 : gap_q + {4'h0, gap_q != 5'h1F};
			if (i_reg_wr && i_reg_addr == A_CTRL) begin
				ctrl_q <= i_reg_wdata[11:0];
				stab_q <= 6'h00;
			end else if ((!sn_q && i_sync_n) || (!sr_q && i_sysref)) begin
				stab_q <= 6'h00; // a sync may restart the phase
			end else begin
				stab_q <= stab_q + {5'h00, !calm};
			end
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	chk_read_answer: assert property (i_reg_rd |-> ##2 o_reg_rvalid)
		else $error("read not answered after two cycles");
	chk_answer_cause: assert property (o_reg_rvalid |-> $past(i_reg_rd, 2))
		else $error("read answer without a read");
	chk_bypass_word: assert property (calm && mode == 3'h0 |->
		o_dout_i_a == {$past(i_sample_a), BYP_Z} && o_dout_i_b == {$past(i_sample_b), BYP_Z})
		else $error("bypass word differs from sample");
	chk_bypass_rate: assert property (calm && mode == 3'h0 |-> o_dout_valid)
		else $error("bypass not at full rate");
	chk_strobe_gap: assert property (calm && mode != 3'h0 && o_dout_valid |-> gap_q == fact)
		else $error("strobe period differs from factor");
	chk_real_q_zero: assert property (calm && mode == 3'h1 && o_dout_valid |->
		o_dout_q_a == 16'h0000 && o_dout_q_b == 16'h0000)
		else $error("real mode drives quadrature word");
	chk_link_mirror: assert property (stab_q > 6'h03 |-> o_link_enable == ctrl_q[B_LINK])
		else $error("link enable not mirrored");
	chk_reset_quiet: assert property ($fell(i_rst) |->
		!o_reg_rvalid && !o_link_enable && o_dout_i_a == 16'h0000)
		else $error("outputs not cleared by reset");
	cov_dec16: cover property (calm && mode == 3'h4 && o_dout_valid);
	cov_read: cover property (o_reg_rvalid);
	cov_lane_sync: cover property (!sn_q && i_sync_n && ctrl_q[B_ILA]);
endmodule : ddc_nco_decim_chk

bind ddc_nco_decim ddc_nco_decim_chk i_ddc_nco_decim_chk (.i_clk, .i_rst, .i_sample_a,
	.i_sample_b, .i_sync_n, .i_sysref, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
	.o_reg_rvalid, .o_dout_valid, .o_dout_i_a, .o_dout_q_a, .o_dout_i_b, .o_dout_q_b,
	.o_link_enable);

// ==== tb/ddc_nco_decim_tb.sv ====
// self-checking bench for the down-converter datapath
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_count++; \
	$display("wrong value %s exp %0h got %0h", nm, ex, got); end end
module ddc_nco_decim_tb;
	import ddc_pkg::*;
	logic              i_clk, i_rst, i_sync_n, i_reg_wr, i_reg_rd, o_reg_rvalid;
	logic              o_dout_valid, o_link_enable, slow, sr_run, sr_pulse, l0;
	logic              i_sysref = 1'b0;
	logic [SAMP_W-1:0] i_sample_a = 12'h000, i_sample_b = 12'h000, s;
	logic [1:0]        i_ovr_a = 2'h0, i_ovr_b = 2'h0, ovr_v;
	logic [4:0]        i_reg_addr, sr_cnt = 5'h00;
	logic [31:0]       i_reg_wdata, o_reg_rdata, rnd, ex, exp_q[$], wv[16];
	logic [WORD_W-1:0] o_dout_i_a, o_dout_q_a, o_dout_i_b, o_dout_q_b;
	logic [6:0]        mode_tab[6] = '{7'h10, 7'h20, 7'h28, 7'h30, 7'h40, 7'h70};
	int                fact_tab[6] = '{2, 4, 4, 8, 16, 1};
	int                err_count, check_count, n;
	integer            seed = 32'h0000_f4d6;
	ddc_nco_decim i_ddc_nco_decim (.i_clk, .i_rst, .i_sample_a, .i_sample_b, .i_ovr_a,
		.i_ovr_b, .i_sync_n, .i_sysref, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
		.o_reg_rdata, .o_reg_rvalid, .o_dout_valid, .o_dout_i_a, .o_dout_q_a, .o_dout_i_b,
		.o_dout_q_b, .o_link_enable);
	ddc_link_rx i_ddc_link_rx (.i_clk, .i_rst, .i_link_enable(o_link_enable), .i_slow(slow),
		.o_sync_n(i_sync_n));
	// 25 MHz clock
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	// random samples, steady overrange, reference source
	always @(posedge i_clk) begin
		i_sample_a <= SAMP_W'($random(seed));
		i_sample_b <= SAMP_W'($random(seed));
		i_ovr_a    <= ovr_v;
		i_ovr_b    <= ~ovr_v;
		sr_cnt     <= sr_cnt + 5'h01;
		i_sysref   <= sr_pulse | (sr_run & (sr_cnt < 5'h04));
	end
	// read answers against the oldest note
	always @(posedge i_clk) begin
		if (o_reg_rvalid === 1'b1) begin
			ex = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hDEAD_BEEF;
			`CHK("read data", ex, o_reg_rdata)
		end
	end
	// one register write cycle
	task automatic reg_wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_reg_wr    <= 1'b1;
		i_reg_addr  <= a;
		i_reg_wdata <= d;
		@(posedge i_clk);
		i_reg_wr <= 1'b0;
	endtask : reg_wr
	// one register read, expected value noted
	task automatic reg_rd(input logic [4:0] a, input logic [31:0] e);
		@(posedge i_clk);
		i_reg_rd   <= 1'b1;
		i_reg_addr <= a;
		exp_q.push_back(e);
		@(posedge i_clk);
		i_reg_rd <= 1'b0;
		repeat (3) @(posedge i_clk);
	endtask : reg_rd
	// next output strobe, cycles counted
	task automatic wait_valid(output int c);
		c = 0;
		do begin
			@(posedge i_clk);
			c++;
		end while (o_dout_valid !== 1'b1 && c < 40);
	endtask : wait_valid
	// verdict and end of run
	task automatic final_report();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : final_report
	// hang guard
	initial begin
		repeat (8000) @(posedge i_clk);
		err_count++;
		final_report();
	end
	// main sequence
	initial begin
		{i_rst, i_reg_wr, i_reg_rd, slow, sr_run, sr_pulse} = 6'b10_0000;
		{i_reg_addr, i_reg_wdata, ovr_v} = '0;
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		reg_rd(A_CTRL, 32'h0000_0000);
		reg_rd(A_STAT, 32'h0000_0000);
		// all word slots, written first so aliasing shows
		for (int k = 0; k < 16; k++) begin
			wv[k] = $random(seed);
			reg_wr(5'(k), wv[k]);
		end
		for (int k = 0; k < 16; k++) begin
			reg_rd(5'(k), (k < 8) ? wv[k] : (wv[k] & PH_MASK));
		end
		reg_wr(5'h1F, 32'hFFFF_FFFF); // unmapped slot ignored
		reg_rd(5'h1F, 32'h0000_0000);
		reg_rd(5'h13, 32'h0000_0000);
		reg_wr(A_RDIV, 32'h0000_1388);
		reg_rd(A_RDIV, 32'h0000_1388);
		reg_wr(A_RDIV, 32'h0000_0780);
		reg_rd(A_RDIV, 32'h0000_0780);
		// rational word for 5.02 MHz on 10 kHz steps, rounded
		reg_wr(A_FREQ_B, 32'h010B_BBBC);
		reg_rd(A_FREQ_B, 32'(((64'd1 << 26) * 64'd502 + 64'd960) / 64'd1920));
		reg_wr(A_RDIV, 32'h0000_0000); // basic mode
		// bypass path, one clock late and full rate
		ovr_v <= 2'b01;
		repeat (70) @(posedge i_clk);
		for (int k = 0; k < 6; k++) begin
			s = i_sample_a;
			@(posedge i_clk);
			`CHK("bypass word", {s, BYP_Z}, o_dout_i_a)
		end
		// each decimating code, the wide dec4 set and one unknown code, with random nco selects
		for (int j = 0; j < 6; j++) begin
			reg_wr(A_CTRL, {20'h0_0000, 2'($random(seed)), 2'($random(seed)), 1'b0, mode_tab[j]});
			repeat (70) @(posedge i_clk);
			wait_valid(n);
			l0 = o_dout_i_a[0];
			wait_valid(n);
			`CHK("strobe gap", fact_tab[j], n)
			if (j == 0) begin
				`CHK("real lsb swap", 1'b1, l0 ^ o_dout_i_a[0])
				`CHK("real q word", 16'h0000, o_dout_q_a)
			end else if (j < 5) begin
				`CHK("cplx lsbs", 4'b1001, {o_dout_i_a[0], o_dout_q_a[0], o_dout_i_b[0],
					o_dout_q_b[0]})
			end
		end
		// lane alignment sync, prompt then slow receiver
		for (int k = 0; k < 2; k++) begin
			slow <= k[0];
			reg_wr(A_CTRL, 32'h0000_0001);
			reg_wr(A_CTRL, 32'h0000_0005);
			repeat (60) @(posedge i_clk);
			`CHK("link enable", 1'b1, o_link_enable)
			reg_rd(A_STAT, 32'(k + 1));
		end
		reg_wr(A_CTRL, 32'h0000_0000);
		reg_wr(A_CTRL, 32'h0000_0004); // no alignment sync wanted
		repeat (60) @(posedge i_clk);
		reg_rd(A_STAT, 32'h0000_0002);
		// two reference pulses after one arming with reference low, only the first counted
		reg_wr(A_FREQ_A, wv[3]);
		reg_wr(A_CTRL, 32'h0000_0006);
		for (int k = 0; k < 2; k++) begin
			sr_pulse <= 1'b1;
			@(posedge i_clk);
			sr_pulse <= 1'b0;
			repeat (8) @(posedge i_clk);
			reg_rd(A_STAT, 32'h0000_0003);
		end
		reg_rd(A_CTRL, 32'h0000_0004);
		// running reference, arm between two rising edges
		sr_run <= 1'b1;
		while (i_sysref !== 1'b1) @(posedge i_clk);
		reg_wr(A_CTRL, 32'h0000_0006);
		repeat (80) @(posedge i_clk);
		reg_rd(A_STAT, 32'h0000_0004);
		sr_run <= 1'b0;
		`CHK("reads left", 0, exp_q.size())
		final_report();
	end
endmodule : ddc_nco_decim_tb

// ==== verilog/ddc_nco_decim.sv ====
// nco, mixer, nco synchronisation and half-band decimation for two channels
`timescale 1ns/100ps
module ddc_nco_decim (
	// clock and reset
	input  wire logic                       i_clk,
	input  wire logic                       i_rst,
	// converter samples and overrange flags (bit0 low, bit1 high)
	input  wire logic [ddc_pkg::SAMP_W-1:0] i_sample_a,
	input  wire logic [ddc_pkg::SAMP_W-1:0] i_sample_b,
	input  wire logic [1:0]                 i_ovr_a,
	input  wire logic [1:0]                 i_ovr_b,
	// link side timing inputs
	input  wire logic                       i_sync_n,
	input  wire logic                       i_sysref,
	// register access port
	input  wire logic                       i_reg_wr,
	input  wire logic                       i_reg_rd,
	input  wire logic [4:0]                 i_reg_addr,
	input  wire logic [31:0]                i_reg_wdata,
	output logic      [31:0]                o_reg_rdata,
	output logic                            o_reg_rvalid,
	// output words toward the link transmitter
	output logic                            o_dout_valid,
	output logic      [ddc_pkg::WORD_W-1:0] o_dout_i_a,
	output logic      [ddc_pkg::WORD_W-1:0] o_dout_q_a,
	output logic      [ddc_pkg::WORD_W-1:0] o_dout_i_b,
	output logic      [ddc_pkg::WORD_W-1:0] o_dout_q_b,
	output logic                            o_link_enable
);
	import ddc_pkg::*;

	// whole state of the block
	typedef struct packed {
		logic [CH_N*NCO_N-1:0][ACC_W-1:0]            acc;     // phase accumulators
		logic [21:0]                                 rcnt;    // rational period count
		logic [15:0]                                 rdiv;    // rational_divider
		logic                                        ila;     // sync_on_lane_alignment
		logic                                        nxt;     // sync_on_next_reference
		logic                                        link;    // link_enable
		logic                                        d4w;     // dec4_wide_passband
		ddc_dec_t                                    dec;     // link_mode_select
		logic [1:0]                                  sel_a;   // selected nco a
		logic [1:0]                                  sel_b;   // selected nco b
		logic                                        sync_p;  // previous sync level
		logic                                        ref_p;   // previous sysref level
		logic [7:0]                                  scnt;    // sync event counter
		logic [CH_N-1:0][ST_N-1:0][1:0][TAP_N-1:0][OUT_W-1:0] tap; // delay lines
		logic [ST_N-1:0]                             ph;      // input parity per stage
		logic [ST_N-1:0]                             sv;      // stage output valid
		logic [CH_N-1:0][ST_N-1:0][1:0][OUT_W-1:0]   so;      // stage outputs i/q
		logic                                        even;    // real sample parity
		logic                                        ovld;    // output valid
		logic [CH_N-1:0][1:0][WORD_W-1:0]            dout;    // output words
		logic                                        rpend;   // read in flight
		logic [4:0]                                  raddr;   // read index
		logic [31:0]                                 rdata;   // read data
		logic                                        rvld;    // read data valid
	} ddc_state_t;

	ddc_state_t r;  // registered state
	ddc_state_t n;  // next state

	logic [31:0]                 mem_rdata;  // word memory readback
	logic [MEM_N-1:0][31:0]      words;      // all stored words
	logic                        mem_wr;     // word memory write
	logic [31:0]                 mem_wdata;  // masked write data

	// stage count for a decimation setting
	function automatic int ddc_nst(input ddc_dec_t d);
		case (d)
			DDC_DEC2:  ddc_nst = 1;
			DDC_DEC4:  ddc_nst = 2;
			DDC_DEC8:  ddc_nst = 3;
			DDC_DEC16: ddc_nst = 4;
			default:   ddc_nst = 0;
		endcase
	endfunction : ddc_nst

	// frequency words in 0..7, phase words in 8..15
	assign mem_wr    = i_reg_wr && (i_reg_addr < A_CTRL);
	assign mem_wdata = i_reg_addr[3] ? (i_reg_wdata & PH_MASK) : i_reg_wdata;

	// word store
	ddc_word_mem u_mem (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_wr    (mem_wr),
		.i_waddr (i_reg_addr[3:0]),
		.i_wdata (mem_wdata),
		.i_raddr (i_reg_addr[3:0]),
		.o_rdata (mem_rdata),
		.o_words (words)
	);

	// next state: registers, sync, ncos, mixer, filters, output words
	always_comb begin
		logic                     ev_ila;   // lane-alignment sync event
		logic                     ev_ref;   // reference sync event
		logic                     syn;      // any sync event
		logic                     wrap;     // rational period end
		logic [21:0]              rlast;    // last count of the period
		logic [1:0]               sel;      // selected nco
		logic [ACC_W-1:0]         phs;      // mixer phase
		logic signed [23:0]       pc;       // sample times cosine
		logic signed [23:0]       ps;       // negated sample times sine
		logic [SAMP_W-1:0]        smp;      // channel sample
		logic [1:0]               ovr;      // channel overrange flags
		logic                     vin;      // stage input valid
		logic                     wide;     // stage uses wide set
		int                       ns;       // stages in use
		n       = r;
		ev_ila  = 1'b0;
		ev_ref  = 1'b0;
		syn     = 1'b0;
		wrap    = 1'b0;
		rlast   = '0;
		sel     = '0;
		phs     = '0;
		pc      = '0;
		ps      = '0;
		smp     = '0;
		ovr     = '0;
		vin     = 1'b0;
		wide    = 1'b0;
		ns      = ddc_nst(r.dec);

		// edge history of the link inputs
		n.sync_p = i_sync_n;
		n.ref_p  = i_sysref;

		// release of sync after code group sync, when enabled
		ev_ila = r.ila && r.link && !r.sync_p && i_sync_n;
		// armed reference edge; arming clears itself when used
		ev_ref = r.nxt && !r.ref_p && i_sysref;
		syn    = ev_ila || ev_ref;
		if (ev_ref) begin
			n.nxt = 1'b0;
		end
		if (syn) begin
			n.scnt = r.scnt + 8'h01;
		end

		// register writes; a write of the arm bit wins over its self clear
		if (i_reg_wr && i_reg_addr == A_CTRL) begin
			n.ila   = i_reg_wdata[B_ILA];
			n.nxt   = i_reg_wdata[B_NEXT];
			n.link  = i_reg_wdata[B_LINK];
			n.d4w   = i_reg_wdata[B_D4W];
			n.dec   = ddc_dec_t'(i_reg_wdata[F_DEC +: 3]);
			n.sel_a = i_reg_wdata[F_SELA +: 2];
			n.sel_b = i_reg_wdata[F_SELB +: 2];
		end
		if (i_reg_wr && i_reg_addr == A_RDIV) begin
			n.rdiv = i_reg_wdata[15:0];
		end

		// register reads: issue, then capture one cycle later
		n.rvld  = r.rpend;
		n.rpend = i_reg_rd;
		if (i_reg_rd) begin
			n.raddr = i_reg_addr;
		end
		if (r.rpend) begin
			case (r.raddr)
				A_CTRL:  n.rdata = {20'h0_0000, r.sel_b, r.sel_a, 1'b0, r.dec,
				                    r.d4w, r.link, r.nxt, r.ila};
				A_RDIV:  n.rdata = {16'h0000, r.rdiv};
				A_STAT:  n.rdata = {24'h00_0000, r.scnt};
				default: n.rdata = (r.raddr < A_CTRL) ? mem_rdata : 32'h0000_0000;
			endcase
		end

		// rational mode: every 64 x divider clocks the ideal phase is whole turns
		rlast = {r.rdiv, RDIV_PAD} - RCNT_ONE;
		wrap  = (r.rdiv != 16'h0000) && (r.rcnt == rlast);
		n.rcnt = (syn || wrap || r.rdiv == 16'h0000) ? '0 : r.rcnt + RCNT_ONE;

		// all accumulators run continuously, selected or not
		for (int k = 0; k < CH_N * NCO_N; k++) begin
			if (syn || wrap) begin
				n.acc[k] = '0;
			end else begin
				n.acc[k] = r.acc[k] + words[k];
			end
		end

		// per channel: mix, then run the half-band cascade
		for (int c = 0; c < CH_N; c++) begin
			sel = (c == 0) ? r.sel_a : r.sel_b;
			smp = (c == 0) ? i_sample_a : i_sample_b;
			ovr = (c == 0) ? i_ovr_a : i_ovr_b;
			phs = r.acc[c * NCO_N + int'(sel)]
			      + {words[MEM_N / 2 + c * NCO_N + int'(sel)][PH_W-1:0], PH_ZERO};
			pc  = $signed(smp) * ddc_sin(phs[31:26] + 6'h10);
			ps  = -($signed(smp) * ddc_sin(phs[31:26]));
			for (int s = 0; s < ST_N; s++) begin
				vin  = (s == 0) ? 1'b1 : r.sv[s-1];
				wide = r.d4w && r.dec == DDC_DEC4 && s == 1;
				if (c == 0) begin
					n.sv[s] = 1'b0;
				end
				if (vin) begin
					n.tap[c][s][0][TAP_N-1:1] = r.tap[c][s][0][TAP_N-2:0];
					n.tap[c][s][1][TAP_N-1:1] = r.tap[c][s][1][TAP_N-2:0];
					if (s != 0) begin
						n.tap[c][s][0][0] = r.so[c][s-1][0];
						n.tap[c][s][1][0] = r.so[c][s-1][1];
					end else if (r.dec == DDC_DEC2) begin
						n.tap[c][s][0][0] = {smp, FILL_Z};
						n.tap[c][s][1][0] = '0;
					end else begin
						n.tap[c][s][0][0] = pc[22:8];
						n.tap[c][s][1][0] = ps[22:8];
					end
					if (c == 0) begin
						n.ph[s] = !r.ph[s];
						n.sv[s] = r.ph[s];
					end
					if (r.ph[s]) begin
						n.so[c][s][0] = ddc_hb(n.tap[c][s][0], wide);
						n.so[c][s][1] = ddc_hb(n.tap[c][s][1], wide);
					end
				end
			end

			// output words
			if (r.dec == DDC_BYPASS || ns == 0) begin
				n.dout[c][0] = {smp, BYP_Z};
				n.dout[c][1] = '0;
			end else if (r.sv[ns-1] && r.dec == DDC_DEC2) begin
				n.dout[c][0] = {r.so[c][0][0], r.even ? ovr[0] : ovr[1]};
				n.dout[c][1] = '0;
			end else if (r.sv[ns-1]) begin
				n.dout[c][0] = {r.so[c][ns-1][0], ovr[0]};
				n.dout[c][1] = {r.so[c][ns-1][1], ovr[1]};
			end
		end

		// output strobe: every clock in bypass, else once per factor clocks
		if (r.dec == DDC_BYPASS || ns == 0) begin
			n.ovld = 1'b1;
			n.even = 1'b1;
		end else begin
			n.ovld = r.sv[ns-1];
			if (r.sv[ns-1]) begin
				n.even = !r.even;
			end
		end
		if (syn) begin
			n.even = 1'b1;
		end
	end

	// state register
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			r      <= '0;
			r.dec  <= DDC_BYPASS;
			r.even <= 1'b1;
			r.sync_p <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// outputs straight from state
	assign o_reg_rdata   = r.rdata;
	assign o_reg_rvalid  = r.rvld;
	assign o_dout_valid  = r.ovld;
	assign o_dout_i_a    = r.dout[0][0];
	assign o_dout_q_a    = r.dout[0][1];
	assign o_dout_i_b    = r.dout[1][0];
	assign o_dout_q_b    = r.dout[1][1];
	assign o_link_enable = r.link;
endmodule : ddc_nco_decim

// ==== verilog/ddc_word_mem.sv ====
// frequency and phase word store with registered readback
`timescale 1ns/100ps
module ddc_word_mem (
	// clock and reset
	input  wire logic                           i_clk,
	input  wire logic                           i_rst,
	// write port
	input  wire logic                           i_wr,
	input  wire logic [3:0]                     i_waddr,
	input  wire logic [31:0]                    i_wdata,
	// read port
	input  wire logic [3:0]                     i_raddr,
	output logic      [31:0]                    o_rdata,
	// all words, for the accumulators and the mixer phase offsets
	output logic      [ddc_pkg::MEM_N-1:0][31:0] o_words
);
	import ddc_pkg::*;

	ddc_mem_state_t r;  // registered state
	ddc_mem_state_t n;  // next state

	// write and read
	always_comb begin
		n = r;
		n.rd = r.w[i_raddr];
		if (i_wr) begin
			n.w[i_waddr] = i_wdata;
		end
	end

	// state register, words clear on reset
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign o_rdata = r.rd;
	assign o_words = r.w;
endmodule : ddc_word_mem
